// ===== include/urx_pkg.sv
package urx_pkg;
    // register byte offsets
    localparam logic [7:0] URX_OFF_PID    = 8'h2c;
    localparam logic [7:0] URX_OFF_EP     = 8'h30;
    localparam logic [7:0] URX_OFF_MATCH  = 8'h34;
    localparam logic [7:0] URX_OFF_SFMASK = 8'h38;
    localparam logic [7:0] URX_OFF_PWR    = 8'h3c;
    localparam logic [7:0] URX_OFF_PHY    = 8'h40;
    localparam logic [7:0] URX_OFF_ISTAT  = 8'h44;
    localparam logic [7:0] URX_OFF_IMASK  = 8'h48;
    localparam logic [7:0] URX_OFF_LINE   = 8'h4c;
    // field positions and power word width
    localparam int unsigned URX_EPV_BIT   = 4;
    localparam int unsigned URX_PWR_W     = 9;
    localparam int unsigned URX_PD_BIT    = 18;
    localparam int unsigned URX_RSE0_BIT  = 13;
    localparam int unsigned URX_RK_BIT    = 12;
    localparam int unsigned URX_FEXP_LSB  = 8;
    localparam int unsigned URX_SRES_BIT  = 7;
    localparam int unsigned URX_CONF_LSB  = 4;
    // interrupt status bits
    localparam int unsigned URX_IRQ_PKT   = 0;
    localparam int unsigned URX_IRQ_TOK   = 1;
    localparam int unsigned URX_IRQ_RSE0  = 2;
    localparam int unsigned URX_IRQ_RK    = 3;
    localparam int unsigned URX_IRQ_W     = 4;
    // reset word and special endpoint mark
    localparam logic [31:0] URX_RST_WORD  = 32'h0000_0000;
    localparam logic [4:0]  URX_SPECIAL   = 5'h10;
    // linestate codes
    localparam logic [1:0]  URX_LS_SE0    = 2'h0;
    localparam logic [1:0]  URX_LS_J      = 2'h1;
    localparam logic [1:0]  URX_LS_K      = 2'h2;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } urx_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } urx_apb_rsp_t;

    // strobes from the packet decoder
    typedef struct packed {
        logic       pkt_stb;
        logic [3:0] pid;
        logic       tok_stb;
        logic [3:0] ep;
    } urx_rx_evt_t;

    // endpoint as presented on the receive port
    typedef struct packed {
        logic       stb;
        logic [4:0] ep;
    } urx_rx_port_t;
endpackage : urx_pkg

// ===== src/urx_lsfilt.sv
`timescale 1ns/1ns
module urx_lsfilt import urx_pkg::*; #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] ls_pin,
    input  wire logic [3:0] filt_exp,
    output logic      [1:0] ls_filt,
    output logic            ls_chg
);
    logic [1:0]       s1_q, s2_q, s3_q;   // pin synchroniser
    logic [1:0]       stab_q, stab_d;     // value once s2 and s3 agree
    logic [1:0]       filt_q, filt_d;     // propagated linestate
    logic [1:0]       cand_q, cand_d;     // value being timed
    logic [CNT_W-1:0] cnt_q, cnt_d;       // cycles the candidate has held
    logic             chg_q, chg_d;
    logic [CNT_W-1:0] lim;

    assign lim = CNT_W'(1) << filt_exp;

    // next values: restart on every new candidate
    always_comb begin
        stab_d = (s2_q == s3_q) ? s3_q : stab_q;
        filt_d = filt_q;
        cand_d = stab_q;
        cnt_d  = '0;
        chg_d  = 1'b0;
        if (stab_q != filt_q && stab_q == cand_q) begin
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_d == lim) begin
                filt_d = stab_q;
                chg_d  = 1'b1;
                cnt_d  = '0;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            stab_q <= '0;
            filt_q <= '0;
            cand_q <= '0;
            cnt_q  <= '0;
            chg_q  <= 1'b0;
        end else begin
            s1_q   <= ls_pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            stab_q <= stab_d;
            filt_q <= filt_d;
            cand_q <= cand_d;
            cnt_q  <= cnt_d;
            chg_q  <= chg_d;
        end
    end

    assign ls_filt = filt_q;
    assign ls_chg  = chg_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_filt_delay;
        (filt_exp == 4'h1 && stab_q != filt_q && $stable(stab_q) && cnt_q == '0
            && cand_q == stab_q) |=> ##0 (filt_q != $past(stab_q)) ##1 filt_q == $past(stab_q, 2);
    endproperty
    a_filt_delay: assert property (p_filt_delay) else $error("linestate passed early");
endmodule : urx_lsfilt

// ===== src/urx_resume.sv
`timescale 1ns/1ns
module urx_resume import urx_pkg::*; (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       auto_en,
    input  wire logic       suspended,
    input  wire logic [1:0] ls_filt,
    input  wire logic       ls_chg,
    output logic            resume_req,
    output logic            set_rse0,
    output logic            set_rk
);
    typedef enum logic [1:0] {URX_RUN, URX_SUSP, URX_WAKE} urx_rs_state_t;

    urx_rs_state_t st_q, st_d;
    logic          rse0_q, rse0_d;  // reset signalling seen
    logic          rk_q, rk_d;      // k resume seen

    // wake only while the controller is enabled, else software polls
    always_comb begin
        st_d   = st_q;
        rse0_d = 1'b0;
        rk_d   = 1'b0;
        unique case (st_q)
            URX_RUN: begin
                if (suspended) st_d = URX_SUSP;
            end
            URX_SUSP: begin
                if (!suspended) begin
                    st_d = URX_RUN;
                end else if (auto_en && ls_chg) begin
                    rse0_d = (ls_filt == URX_LS_SE0);
                    rk_d   = (ls_filt == URX_LS_K);
                    if (rse0_d || rk_d) st_d = URX_WAKE;
                end
            end
            URX_WAKE: begin
                if (!suspended) st_d = URX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q   <= URX_RUN;
            rse0_q <= 1'b0;
            rk_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            rse0_q <= rse0_d;
            rk_q   <= rk_d;
        end
    end

    assign set_rse0   = rse0_q;
    assign set_rk     = rk_q;
    assign resume_req = rse0_q | rk_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_no_auto;
        !auto_en |=> !resume_req;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("wake while disabled");
endmodule : urx_resume

// ===== src/urx_top.sv
// Function
// - store last received packet identifier, read-only
// - store last token endpoint number, read-only
// - flag stored endpoint as valid
// - per-endpoint mask ors 0x10 onto port
// - control bit disables both data port pulldowns
// - auto-resume on se0 sets reset flag
// - auto-resume on k sets resume flag
// - linestate change delayed two-power-n clocks
// - suspend controller resumes only when enabled
// - control field drives transceiver config pins
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module urx_top import urx_pkg::*; #(
    parameter int unsigned FILT_CNT_W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire urx_apb_req_t apb_req,
    output urx_apb_rsp_t      apb_rsp,
    input  wire urx_rx_evt_t  rx_evt,
    output urx_rx_port_t      rx_port,
    input  wire logic [1:0]   ls_pin,
    input  wire logic         suspended,
    output logic              resume_req,
    output logic              data_port_a_pd_dis,
    output logic              data_port_b_pd_dis,
    output logic [2:0]        transceiver_config_pins,
    output logic [1:0]        ls_filt,
    output logic              irq
);
    // captured receive state
    logic [3:0]           pid_q, pid_d;        // last packet identifier
    logic [3:0]           ep_q, ep_d;          // last token endpoint
    logic                 epv_q, epv_d;        // endpoint holds a value
    urx_rx_port_t         port_q, port_d;      // endpoint to receive port
    // software registers
    logic [15:0]          match_q, match_d;    // special endpoint mask
    logic [31:0]          sfmask_q, sfmask_d;  // session flag mask
    logic [URX_PWR_W-1:0] pwr_q, pwr_d;        // power signalling word
    logic                 pd_q, pd_d;          // pulldown disable
    logic                 rse0_q, rse0_d;      // resume was reset
    logic                 rk_q, rk_d;          // resume was k
    logic [3:0]           fexp_q, fexp_d;      // filter exponent
    logic                 sres_q, sres_d;      // auto-resume enable
    logic [2:0]           conf_q, conf_d;      // transceiver config
    logic [URX_IRQ_W-1:0] ist_q, ist_d;        // sticky event status
    logic [URX_IRQ_W-1:0] imsk_q, imsk_d;      // event mask
    logic [31:0]          rdat_q, rdat_d;      // read data register
    // bus decode
    logic                 setup, access, wr, rd, hit;
    logic [31:0]          mux;
    logic [31:0]          phy_word;
    logic [URX_IRQ_W-1:0] evt, rd_clr;
    // from the helpers
    logic                 ls_chg, set_rse0, set_rk;

    // linestate filter with pin synchroniser
    urx_lsfilt #(
        .CNT_W   (FILT_CNT_W)
    ) u_filt (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ls_pin   (ls_pin),
        .filt_exp (fexp_q),
        .ls_filt  (ls_filt),
        .ls_chg   (ls_chg)
    );

    // resume detector for the suspend controller
    urx_resume u_res (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .auto_en    (sres_q),
        .suspended  (suspended),
        .ls_filt    (ls_filt),
        .ls_chg     (ls_chg),
        .resume_req (resume_req),
        .set_rse0   (set_rse0),
        .set_rk     (set_rk)
    );

    // apb phases; zero wait states
    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;

    // address decode: only the exact aligned words answer
    always_comb begin
        unique case (apb_req.paddr)
            URX_OFF_PID, URX_OFF_EP, URX_OFF_MATCH,
            URX_OFF_SFMASK, URX_OFF_PWR, URX_OFF_PHY,
            URX_OFF_ISTAT, URX_OFF_IMASK, URX_OFF_LINE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign wr = access & apb_req.pwrite & hit;
    assign rd = access & ~apb_req.pwrite & hit;

    // control word as it reads back, reserved bits zero
    always_comb begin
        phy_word                     = URX_RST_WORD;
        phy_word[URX_PD_BIT]         = pd_q;
        phy_word[URX_RSE0_BIT]       = rse0_q;
        phy_word[URX_RK_BIT]         = rk_q;
        phy_word[URX_FEXP_LSB +: 4]  = fexp_q;
        phy_word[URX_SRES_BIT]       = sres_q;
        phy_word[URX_CONF_LSB +: 3]  = conf_q;
    end

    // read mux; unmapped words read zero
    always_comb begin
        mux = URX_RST_WORD;
        unique case (apb_req.paddr)
            URX_OFF_PID:    mux[3:0] = pid_q;
            URX_OFF_EP:     mux[4:0] = {epv_q, ep_q};
            URX_OFF_MATCH:  mux[15:0] = match_q;
            URX_OFF_SFMASK: mux = sfmask_q;
            URX_OFF_PWR:    mux[URX_PWR_W-1:0] = pwr_q;
            URX_OFF_PHY:    mux = phy_word;
            URX_OFF_ISTAT:  mux[URX_IRQ_W-1:0] = ist_q;
            URX_OFF_IMASK:  mux[URX_IRQ_W-1:0] = imsk_q;
            URX_OFF_LINE:   mux[1:0] = ls_filt;        // polled when auto-resume off
            default:        mux = URX_RST_WORD;
        endcase
    end

    // events that raise the interrupt
    always_comb begin
        evt               = '0;
        evt[URX_IRQ_PKT]  = rx_evt.pkt_stb;
        evt[URX_IRQ_TOK]  = rx_evt.tok_stb;
        evt[URX_IRQ_RSE0] = set_rse0;
        evt[URX_IRQ_RK]   = set_rk;
    end

    // clear only what the read actually returned, so late events survive
    assign rd_clr = (rd && apb_req.paddr == URX_OFF_ISTAT) ? rdat_q[URX_IRQ_W-1:0] : '0;

    // next-state for all registers
    always_comb begin
        pid_d    = pid_q;
        ep_d     = ep_q;
        epv_d    = epv_q;
        port_d   = '{stb: 1'b0, ep: port_q.ep};
        match_d  = match_q;
        sfmask_d = sfmask_q;
        pwr_d    = pwr_q;
        pd_d     = pd_q;
        rse0_d   = rse0_q;
        rk_d     = rk_q;
        fexp_d   = fexp_q;
        sres_d   = sres_q;
        conf_d   = conf_q;
        imsk_d   = imsk_q;
        rdat_d   = rdat_q;
        // packet and token capture
        if (rx_evt.pkt_stb) begin
            pid_d = rx_evt.pid;
        end
        if (rx_evt.tok_stb) begin
            ep_d        = rx_evt.ep;
            epv_d       = 1'b1;
            port_d.stb  = 1'b1;
            port_d.ep   = {1'b0, rx_evt.ep}
                        | (match_q[rx_evt.ep] ? URX_SPECIAL : 5'h00);
        end
        // software writes; reserved bits never stored
        if (wr) begin
            unique case (apb_req.paddr)
                URX_OFF_MATCH:  match_d  = apb_req.pwdata[15:0];
                URX_OFF_SFMASK: sfmask_d = apb_req.pwdata;
                URX_OFF_PWR:    pwr_d    = apb_req.pwdata[URX_PWR_W-1:0];
                URX_OFF_PHY: begin
                    pd_d   = apb_req.pwdata[URX_PD_BIT];
                    rse0_d = apb_req.pwdata[URX_RSE0_BIT];
                    rk_d   = apb_req.pwdata[URX_RK_BIT];
                    fexp_d = apb_req.pwdata[URX_FEXP_LSB +: 4];
                    sres_d = apb_req.pwdata[URX_SRES_BIT];
                    conf_d = apb_req.pwdata[URX_CONF_LSB +: 3];
                end
                URX_OFF_IMASK:  imsk_d = apb_req.pwdata[URX_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (set_rse0) begin
            rse0_d = 1'b1;
        end
        if (set_rk) begin
            rk_d = 1'b1;
        end
        ist_d = (ist_q & ~rd_clr) | evt;
        // read data sampled in setup, held through access
        if (setup) begin
            rdat_d = mux;
        end
    end

    // registers only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pid_q    <= '0;
            ep_q     <= '0;
            epv_q    <= 1'b0;
            port_q   <= '0;
            match_q  <= '0;
            sfmask_q <= '0;
            pwr_q    <= '0;
            pd_q     <= 1'b0;
            rse0_q   <= 1'b0;
            rk_q     <= 1'b0;
            fexp_q   <= '0;
            sres_q   <= 1'b0;
            conf_q   <= '0;
            ist_q    <= '0;
            imsk_q   <= '0;
            rdat_q   <= '0;
        end else begin
            pid_q    <= pid_d;
            ep_q     <= ep_d;
            epv_q    <= epv_d;
            port_q   <= port_d;
            match_q  <= match_d;
            sfmask_q <= sfmask_d;
            pwr_q    <= pwr_d;
            pd_q     <= pd_d;
            rse0_q   <= rse0_d;
            rk_q     <= rk_d;
            fexp_q   <= fexp_d;
            sres_q   <= sres_d;
            conf_q   <= conf_d;
            ist_q    <= ist_d;
            imsk_q   <= imsk_d;
            rdat_q   <= rdat_d;
        end
    end

    // outputs
    assign apb_rsp.prdata          = rdat_q;
    assign apb_rsp.pready          = 1'b1;
    assign apb_rsp.pslverr         = access & ~hit;
    assign rx_port                 = port_q;
    assign data_port_a_pd_dis      = pd_q;
    assign data_port_b_pd_dis      = pd_q;
    assign transceiver_config_pins = conf_q;
    assign irq                     = |(ist_q & imsk_q);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_pid_cap;
        rx_evt.pkt_stb |=> pid_q == $past(rx_evt.pid);
    endproperty
    a_pid_cap: assert property (p_pid_cap) else $error("pid not captured");

    property p_ep_cap;
        rx_evt.tok_stb |=> ep_q == $past(rx_evt.ep) && rx_port.stb;
    endproperty
    a_ep_cap: assert property (p_ep_cap) else $error("endpoint not captured");

    property p_ep_valid;
        rx_evt.tok_stb |=> epv_q ##1 epv_q;
    endproperty
    a_ep_valid: assert property (p_ep_valid) else $error("endpoint valid lost");

    property p_special;
        rx_evt.tok_stb |=> rx_port.ep[4] == $past(match_q[rx_evt.ep])
            && rx_port.ep[3:0] == $past(rx_evt.ep);
    endproperty
    a_special: assert property (p_special) else $error("special mark wrong");

    property p_pulldown;
        (wr && apb_req.paddr == URX_OFF_PHY) |=>
            data_port_a_pd_dis == $past(apb_req.pwdata[URX_PD_BIT])
            && data_port_b_pd_dis == $past(apb_req.pwdata[URX_PD_BIT]);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown control wrong");

    property p_rse0_set;
        set_rse0 |=> rse0_q && ist_q[URX_IRQ_RSE0];
    endproperty
    a_rse0_set: assert property (p_rse0_set) else $error("reset flag not set");

    property p_rk_set;
        set_rk |=> rk_q && ist_q[URX_IRQ_RK];
    endproperty
    a_rk_set: assert property (p_rk_set) else $error("resume flag not set");

    property p_conf;
        (wr && apb_req.paddr == URX_OFF_PHY) |=>
            transceiver_config_pins == $past(apb_req.pwdata[6:4]);
    endproperty
    a_conf: assert property (p_conf) else $error("config pins wrong");

    property p_reserved;
        (setup && apb_req.paddr == URX_OFF_PHY) |=> rdat_q[3:0] == 4'h0 && rdat_q[31:19] == '0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
endmodule : urx_top

// ===== tb/urx_xcvr_model.sv
`timescale 1ns/1ns
// stand-in for the transceiver line and the packet decoder
module urx_xcvr_model import urx_pkg::*; (
    input  wire logic  clk_sys,
    output urx_rx_evt_t rx_evt,
    output logic [1:0]  ls_pin
);
    // decoder quiet, line idle at j
    initial begin
        rx_evt = '0;
        ls_pin = URX_LS_J;
    end

    // one token per call; calls back to back strobe every cycle
    task automatic send_tok(input logic [3:0] e);
        @(posedge clk_sys);
        rx_evt.tok_stb <= 1'b1;
        rx_evt.ep      <= e;
    endtask : send_tok

    // one packet identifier per call
    task automatic send_pkt(input logic [3:0] p);
        @(posedge clk_sys);
        rx_evt.pkt_stb <= 1'b1;
        rx_evt.pid     <= p;
    endtask : send_pkt

    // strobes drop; stale fields inverted so nobody leans on them
    task automatic idle();
        @(posedge clk_sys);
        rx_evt.tok_stb <= 1'b0;
        rx_evt.pkt_stb <= 1'b0;
        rx_evt.ep      <= ~rx_evt.ep;
        rx_evt.pid     <= ~rx_evt.pid;
    endtask : idle

    // new line level: se0 for reset signalling, k for resume
    task automatic set_line(input logic [1:0] v);
        @(posedge clk_sys);
        ls_pin <= v;
    endtask : set_line
endmodule : urx_xcvr_model

// ===== tb/usb_rx_status_phy_control_bench.sv
`timescale 1ns/1ns
module usb_rx_status_phy_control_bench import urx_pkg::*;;
    // one expected apb answer
    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } urx_note_t;

    logic         clk_sys     = 1'b0;
    logic         rst         = 1'b1;
    logic         suspended   = 1'b0;
    urx_apb_req_t req         = '0;
    urx_apb_rsp_t rsp;
    urx_rx_evt_t  evt;
    urx_rx_port_t port;
    logic [1:0]   ls_pin;
    logic [1:0]   ls_filt;
    logic         resume_req;
    logic         pd_a;
    logic         pd_b;
    logic         irq;
    logic [2:0]   cfg;
    urx_note_t    nq[$];      // pending apb answers
    urx_note_t    nt;
    logic [4:0]   eq[$];      // pending receive port endpoints
    int           err_count   = 0;
    int           checks_done = 0;
    int           rs_cnt      = 0; // resume pulses seen
    int           d1;
    int           d4;
    logic [31:0]  seed        = 32'h0001_790b;
    logic [31:0]  r;

    // 50 mhz
    always #10 clk_sys = ~clk_sys;

    urx_top i_urx_top (
        .clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .rx_evt(evt), .rx_port(port), .ls_pin(ls_pin), .suspended(suspended),
        .resume_req(resume_req), .data_port_a_pd_dis(pd_a),
        .data_port_b_pd_dis(pd_b), .transceiver_config_pins(cfg),
        .ls_filt(ls_filt), .irq(irq)
    );

    urx_xcvr_model i_urx_xcvr_model (.clk_sys(clk_sys), .rx_evt(evt), .ls_pin(ls_pin));

    // xorshift source, fixed start
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // single compare point
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; idle cycle first so psel is never set twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge clk_sys);
        nq.push_back({exp, err});
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge clk_sys);
        req.penable <= 1'b1;
        // wait for pready; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (rsp.pready !== 1'b1);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        req.pwdata  <= ~d;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    // cycles from a line change to the filtered output
    task automatic meas(input logic [3:0] e, input logic [1:0] v, output int d);
        wr(URX_OFF_PHY, 32'(e) << URX_FEXP_LSB);
        i_urx_xcvr_model.set_line(v);
        d = 0;
        // looked at mid-cycle, away from the edge that launches ls_filt
        while (ls_filt !== v && d < 2000) begin
            @(negedge clk_sys);
            d++;
        end
    endtask : meas

    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // output watcher: every answer and every port strobe takes the oldest note
    always @(posedge clk_sys) begin
        if (resume_req === 1'b1) rs_cnt++;
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            nt = nq.pop_front();
            if (!req.pwrite) chk("prdata", rsp.prdata, nt.data);
            chk("pslverr", 32'(rsp.pslverr), 32'(nt.err));
        end
        if (port.stb === 1'b1) chk("rx port ep", 32'(port.ep), 32'(eq.pop_front()));
    end

    // hang guard, far above the expected run
    initial begin
        #400000;
        err_count++;
        results();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, then the unmapped word both ways
        for (int a = 'h2c; a <= 'h48; a += 4) rd(8'(a), 32'h0);
        rd(URX_OFF_LINE, 32'(URX_LS_J));
        apb(1'b0, 8'h50, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h50, 32'hffff_ffff, 32'h0, 1'b1);
        // all ones: only writable bits stick
        for (int a = 'h2c; a <= 'h40; a += 4) wr(8'(a), 32'hffff_ffff);
        rd(URX_OFF_PID, 32'h0);
        rd(URX_OFF_EP, 32'h0);
        rd(URX_OFF_MATCH, 32'h0000_ffff);
        rd(URX_OFF_SFMASK, 32'hffff_ffff);
        rd(URX_OFF_PWR, 32'h0000_01ff);
        rd(URX_OFF_PHY, 32'h0004_3ff0);
        // every config code, pulldowns toggled alongside
        for (int c = 0; c < 8; c++) begin
            wr(URX_OFF_PHY, (32'(c) << URX_CONF_LSB) | (32'(c & 1) << URX_PD_BIT));
            @(negedge clk_sys);
            chk("config pins", 32'(cfg), 32'(c));
            chk("pulldown dis", 32'({pd_a, pd_b}), 32'((c & 1) * 3));
        end
        // random storage patterns
        repeat (4) begin
            r = xs();
            wr(URX_OFF_SFMASK, r);
            rd(URX_OFF_SFMASK, r);
            wr(URX_OFF_PWR, r);
            rd(URX_OFF_PWR, r & 32'h0000_01ff);
            wr(URX_OFF_MATCH, r);
            rd(URX_OFF_MATCH, r & 32'h0000_ffff);
        end
        // every endpoint, tokens back to back
        for (int e = 0; e < 16; e++) begin
            eq.push_back(5'(e) | (r[e] ? URX_SPECIAL : 5'h00));
            i_urx_xcvr_model.send_tok(4'(e));
        end
        i_urx_xcvr_model.idle();
        rd(URX_OFF_EP, 32'h0000_001f);
        r = xs();
        i_urx_xcvr_model.send_pkt(r[3:0]);
        i_urx_xcvr_model.idle();
        rd(URX_OFF_PID, 32'(r[3:0]));
        // interrupt masked, unmasked, then read-cleared
        @(negedge clk_sys);
        chk("irq masked", 32'(irq), 32'h0);
        wr(URX_OFF_IMASK, 32'h2);
        @(negedge clk_sys);
        chk("irq raised", 32'(irq), 32'h1);
        rd(URX_OFF_ISTAT, 32'h3);
        @(negedge clk_sys);
        chk("irq cleared", 32'(irq), 32'h0);
        rd(URX_OFF_ISTAT, 32'h0);
        // filter delay scales with two to the exponent
        meas(4'h1, URX_LS_K, d1);
        meas(4'h4, URX_LS_J, d4);
        chk("filter delay", 32'(d4 - d1), 32'd14);
        rd(URX_OFF_LINE, 32'(URX_LS_J));
        // auto resume on se0 while suspended
        wr(URX_OFF_PHY, 32'h0000_0080);
        @(posedge clk_sys);
        suspended <= 1'b1;
        i_urx_xcvr_model.set_line(URX_LS_SE0);
        repeat (40) @(posedge clk_sys);
        chk("resume pulses", 32'(rs_cnt), 32'd1);
        rd(URX_OFF_PHY, 32'h0000_2080);
        rd(URX_OFF_ISTAT, 32'h4);
        wr(URX_OFF_PHY, 32'h0000_0080);
        rd(URX_OFF_PHY, 32'h0000_0080);
        // re-arm by a fresh suspend, then k
        i_urx_xcvr_model.set_line(URX_LS_J);
        repeat (20) @(posedge clk_sys);
        suspended <= 1'b0;
        @(posedge clk_sys);
        suspended <= 1'b1;
        i_urx_xcvr_model.set_line(URX_LS_K);
        repeat (40) @(posedge clk_sys);
        chk("resume pulses", 32'(rs_cnt), 32'd2);
        rd(URX_OFF_PHY, 32'h0000_1080);
        rd(URX_OFF_ISTAT, 32'h8);
        wr(URX_OFF_PHY, 32'h0);
        rd(URX_OFF_PHY, 32'h0);
        // auto resume off: software must poll the line
        suspended <= 1'b0;
        @(posedge clk_sys);
        suspended <= 1'b1;
        i_urx_xcvr_model.set_line(URX_LS_SE0);
        repeat (40) @(posedge clk_sys);
        chk("resume pulses", 32'(rs_cnt), 32'd2);
        rd(URX_OFF_PHY, 32'h0);
        rd(URX_OFF_LINE, 32'(URX_LS_SE0));
        repeat (4) @(posedge clk_sys);
        chk("notes left", 32'(nq.size() + eq.size()), 32'h0);
        results();
    end
endmodule : usb_rx_status_phy_control_bench
